/* compact_timer.sv */
// Compact 16-bit timer with compare, PWM and timer modes behind an APB slave
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module compact_timer
  import compact_timer_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              high_clk_tick,
  input  wire logic              tbc_clk_tick,
  input  wire logic              external_count_input,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   timer_output_pin,
  output logic                   irq_pulse
);
  logic [7:0]       ctrl0_ff;
  logic [7:0]       ctrl1_ff;
  logic [15:0]      compare_a_value_ff;
  logic [7:0]       period_compare_value_ff;
  logic [7:0]       byte_buf_ff;
  logic [15:0]      count_ff;
  logic             on_d_ff;
  logic [DIV_W-1:0] sys_div_ff;
  logic [DIV_W-1:0] h_div_ff;
  logic [2:0]       ext_sync_ff;
  logic             pin_ff;
  logic             match_a_flag_ff;
  logic             match_p_flag_ff;

  logic             count_pause;
  logic [2:0]       clock_select;
  logic             module_on;
  logic [1:0]       operating_mode_select;
  logic [1:0]       output_function_select;
  logic             output_initial_level;
  logic             output_invert;
  logic             period_duty_swap;
  logic             clear_source_select;

  assign count_pause            = ctrl0_ff[C0_PAUSE_BIT];
  assign clock_select           = ctrl0_ff[C0_CKSEL_LSB +: 3];
  assign module_on              = ctrl0_ff[C0_ON_BIT];
  assign operating_mode_select  = ctrl1_ff[C1_MODE_LSB +: 2];
  assign output_function_select = ctrl1_ff[C1_IO_LSB +: 2];
  assign output_initial_level   = ctrl1_ff[C1_OC_BIT];
  assign output_invert          = ctrl1_ff[C1_POL_BIT];
  assign period_duty_swap       = ctrl1_ff[C1_DPX_BIT];
  assign clear_source_select    = ctrl1_ff[C1_CCLR_BIT];

  // APB access decode; single-cycle access phase
  logic wr_en;
  logic rd_en;
  assign wr_en = psel && penable && pwrite;
  // Read side effects at setup, the edge that captures the high byte
  assign rd_en = psel && !penable && !pwrite;

  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [4:0] off);
    addr_is = (a == off);
  endfunction : addr_is

  logic on_rise;
  assign on_rise = module_on && !on_d_ff;

  // Control registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl0_ff <= REG_RESET;
      ctrl1_ff <= REG_RESET;
    end else if (wr_en) begin
      if (addr_is(paddr, OFF_CTRL0)) begin
        ctrl0_ff <= pwdata[7:0] & C0_WMASK;
      end
      if (addr_is(paddr, OFF_CTRL1)) begin
        ctrl1_ff <= pwdata[7:0];
      end
    end
  end

  // Compare values and shared byte buffer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      compare_a_value_ff      <= CNT_RESET;
      period_compare_value_ff <= REG_RESET;
      byte_buf_ff             <= REG_RESET;
    end else if (wr_en) begin
      if (addr_is(paddr, OFF_CMPA_LO)) begin
        byte_buf_ff <= pwdata[7:0];
      end
      if (addr_is(paddr, OFF_CMPA_HI)) begin
        compare_a_value_ff <= {pwdata[7:0], byte_buf_ff};
      end
      if (addr_is(paddr, OFF_PERIOD)) begin
        period_compare_value_ff <= pwdata[7:0];
      end
    end else if (rd_en) begin
      if (addr_is(paddr, OFF_CNT_HI)) begin
        byte_buf_ff <= count_ff[7:0];
      end
      if (addr_is(paddr, OFF_CMPA_HI)) begin
        byte_buf_ff <= compare_a_value_ff[7:0];
      end
    end
  end

  // Read data and handshake, all registered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          OFF_CTRL0:   prdata[7:0] <= ctrl0_ff;
          OFF_CTRL1:   prdata[7:0] <= ctrl1_ff;
          OFF_CNT_LO:  prdata[7:0] <= byte_buf_ff;
          OFF_CNT_HI:  prdata[7:0] <= count_ff[15:8];
          OFF_CMPA_LO: prdata[7:0] <= byte_buf_ff;
          OFF_CMPA_HI: prdata[7:0] <= compare_a_value_ff[15:8];
          OFF_PERIOD:  prdata[7:0] <= period_compare_value_ff;
          OFF_STATUS:  prdata[1:0] <= {match_p_flag_ff, match_a_flag_ff};
          default:     prdata      <= 32'h00000000;
        endcase
      end
    end
  end

  // Prescalers and external pin synchroniser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sys_div_ff  <= '0;
      h_div_ff    <= '0;
      ext_sync_ff <= 3'h0;
      on_d_ff     <= 1'b0;
    end else begin
      sys_div_ff  <= sys_div_ff + 1'b1;
      if (high_clk_tick) begin
        h_div_ff <= h_div_ff + 1'b1;
      end
      ext_sync_ff <= {ext_sync_ff[1:0], external_count_input};
      on_d_ff     <= module_on;
    end
  end

  logic tick;
  always_comb begin
    case (clock_select)
      CK_SYS_DIV4: tick = (sys_div_ff[1:0] == 2'h3);
      CK_SYS:      tick = 1'b1;
      CK_H_DIV16:  tick = high_clk_tick && (h_div_ff[3:0] == 4'hF);
      CK_H_DIV64:  tick = high_clk_tick && (h_div_ff[5:0] == 6'h3F);
      CK_TBC:      tick = tbc_clk_tick;
      CK_H_DIV8:   tick = high_clk_tick && (h_div_ff[2:0] == 3'h7);
      CK_EXT_RISE: tick = ext_sync_ff[1] && !ext_sync_ff[2];
      CK_EXT_FALL: tick = !ext_sync_ff[1] && ext_sync_ff[2];
      default:     tick = 1'b0;
    endcase
  end

  // Comparators evaluated on the counter step
  logic        step;
  logic        is_pwm;
  logic        match_a;
  logic        match_p;
  logic        overflow;
  logic        clear_cnt;
  logic [16:0] period_len;
  logic [16:0] duty_len;
  logic        pwm_active;
  assign step     = module_on && !on_rise && !count_pause && tick;
  assign is_pwm   = (operating_mode_select == MODE_PWM);
  assign match_a  = step && (count_ff + 16'h0001 == compare_a_value_ff)
                    && (compare_a_value_ff != CNT_RESET);
  assign match_p  = step && (period_compare_value_ff != REG_RESET)
                    && (count_ff[15:8] == period_compare_value_ff - 8'h01)
                    && (count_ff[7:0] == 8'hFF);
  assign overflow = step && (count_ff == 16'hFFFF);
  // P value 0 means a full 65536-clock span
  assign period_len = (period_compare_value_ff == REG_RESET) ? 17'h10000
                      : {1'b0, period_compare_value_ff, 8'h00};

  always_comb begin
    if (is_pwm) begin
      clear_cnt = period_duty_swap ? match_a : (match_p || overflow);
    end else if (clear_source_select) begin
      clear_cnt = match_a || overflow;
    end else begin
      clear_cnt = match_p || (overflow && period_compare_value_ff == REG_RESET);
    end
  end

  always_comb begin
    if (period_duty_swap) begin
      duty_len = period_len;
    end else begin
      duty_len = {1'b0, compare_a_value_ff};
    end
  end
  // Counter below duty means active; duty at or over period stays active
  logic [16:0] pwm_period;
  assign pwm_period = period_duty_swap ? {1'b0, compare_a_value_ff} : period_len;
  assign pwm_active = ({1'b0, count_ff} < duty_len) || (duty_len >= pwm_period);

  // Main counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_ff <= CNT_RESET;
    end else if (on_rise) begin
      count_ff <= CNT_RESET;
    end else if (clear_cnt) begin
      count_ff <= CNT_RESET;
    end else if (step) begin
      count_ff <= count_ff + 16'h0001;
    end
  end

  // Match flags and interrupt request
  logic set_a;
  logic set_p;
  assign set_a = match_a;
  assign set_p = (match_p || (overflow && period_compare_value_ff == REG_RESET))
                 && (is_pwm || !clear_source_select);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      match_a_flag_ff <= 1'b0;
      match_p_flag_ff <= 1'b0;
      irq_pulse       <= 1'b0;
    end else begin
      // Set wins over a same-cycle software clear
      match_a_flag_ff <= set_a ||
        (match_a_flag_ff && !(wr_en && addr_is(paddr, OFF_STATUS) && pwdata[0]));
      match_p_flag_ff <= set_p ||
        (match_p_flag_ff && !(wr_en && addr_is(paddr, OFF_STATUS) && pwdata[1]));
      irq_pulse       <= clear_cnt || set_a || set_p;
    end
  end

  // Output pin
  logic level_ff;
  logic nxt_level;
  always_comb begin
    nxt_level = level_ff;
    if (operating_mode_select == MODE_CMP) begin
      if (on_rise) begin
        nxt_level = output_initial_level;
      end else if (match_a) begin
        case (output_function_select)
          IO_LOW:    nxt_level = 1'b0;
          IO_HIGH:   nxt_level = 1'b1;
          IO_TOGGLE: nxt_level = !level_ff;
          default:   nxt_level = level_ff;
        endcase
      end
    end else if (is_pwm) begin
      case (output_function_select)
        PWM_INACTIVE: nxt_level = !output_initial_level;
        PWM_ACTIVE:   nxt_level = output_initial_level;
        PWM_WAVE:     nxt_level = pwm_active ? output_initial_level
                                             : !output_initial_level;
        default:      nxt_level = level_ff;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level_ff         <= 1'b0;
      timer_output_pin <= 1'b0;
    end else begin
      level_ff <= nxt_level;
      if (operating_mode_select == MODE_TMR) begin
        timer_output_pin <= 1'b0;
      end else begin
        timer_output_pin <= nxt_level ^ output_invert;
      end
    end
  end
endmodule : compact_timer
`default_nettype wire

/* compact_timer_pkg.sv */
// Package with register map, field layout and constants of the compact timer
package compact_timer_pkg;
  localparam int          ADDR_W         = 5;
  // Register byte addresses, one aligned word each
  localparam logic [4:0]  OFF_CTRL0      = 5'h00;
  localparam logic [4:0]  OFF_CTRL1      = 5'h04;
  localparam logic [4:0]  OFF_CNT_LO     = 5'h08;
  localparam logic [4:0]  OFF_CNT_HI     = 5'h0C;
  localparam logic [4:0]  OFF_CMPA_LO    = 5'h10;
  localparam logic [4:0]  OFF_CMPA_HI    = 5'h14;
  localparam logic [4:0]  OFF_PERIOD     = 5'h18;
  localparam logic [4:0]  OFF_STATUS     = 5'h1C;
  // Control register 0 fields
  localparam int          C0_PAUSE_BIT   = 7;
  localparam int          C0_CKSEL_LSB   = 4;
  localparam int          C0_ON_BIT      = 3;
  localparam logic [7:0]  C0_WMASK       = 8'hF8;
  // Control register 1 fields
  localparam int          C1_MODE_LSB    = 6;
  localparam int          C1_IO_LSB      = 4;
  localparam int          C1_OC_BIT      = 3;
  localparam int          C1_POL_BIT     = 2;
  localparam int          C1_DPX_BIT     = 1;
  localparam int          C1_CCLR_BIT    = 0;
  localparam logic [7:0]  REG_RESET      = 8'h00;
  localparam logic [15:0] CNT_RESET      = 16'h0000;
  // Clock select codes
  localparam logic [2:0]  CK_SYS_DIV4    = 3'h0;
  localparam logic [2:0]  CK_SYS         = 3'h1;
  localparam logic [2:0]  CK_H_DIV16     = 3'h2;
  localparam logic [2:0]  CK_H_DIV64     = 3'h3;
  localparam logic [2:0]  CK_TBC         = 3'h4;
  localparam logic [2:0]  CK_H_DIV8      = 3'h5;
  localparam logic [2:0]  CK_EXT_RISE    = 3'h6;
  localparam logic [2:0]  CK_EXT_FALL    = 3'h7;
  localparam int          DIV_W          = 6;
  // Mode and output function codes
  localparam logic [1:0]  MODE_CMP       = 2'h0;
  localparam logic [1:0]  MODE_PWM       = 2'h2;
  localparam logic [1:0]  MODE_TMR       = 2'h3;
  localparam logic [1:0]  IO_NONE        = 2'h0;
  localparam logic [1:0]  IO_LOW         = 2'h1;
  localparam logic [1:0]  IO_HIGH        = 2'h2;
  localparam logic [1:0]  IO_TOGGLE      = 2'h3;
  localparam logic [1:0]  PWM_INACTIVE   = 2'h0;
  localparam logic [1:0]  PWM_ACTIVE     = 2'h1;
  localparam logic [1:0]  PWM_WAVE       = 2'h2;
endpackage : compact_timer_pkg

/* compact_timer_asserts.sv */
// Port-level assertion checker for the compact timer
`timescale 1ns/1ns
`default_nettype none
module compact_timer_asserts
  import compact_timer_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              timer_output_pin
);
  logic [7:0] ctrl0_ff;
  logic [7:0] ctrl1_ff;
  logic       wr_acc;
  assign wr_acc = psel && penable && pwrite && pready;
  // Shadow copies of the control registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) ctrl0_ff <= REG_RESET;
    else if (wr_acc && paddr == OFF_CTRL0) ctrl0_ff <= pwdata[7:0];
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) ctrl1_ff <= REG_RESET;
    else if (wr_acc && paddr == OFF_CTRL1) ctrl1_ff <= pwdata[7:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence on_rise_s;
    wr_acc && paddr == OFF_CTRL0 && pwdata[C0_ON_BIT] && !ctrl0_ff[C0_ON_BIT];
  endsequence
  chk_ready_access: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_no_error: assert property (!pslverr)
    else $error("slave error raised");
  chk_ctrl0_unused: assert property (pready && !pwrite && paddr == OFF_CTRL0
    |-> prdata[2:0] == 3'h0) else $error("control 0 low bits not zero");
  chk_read_width: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data above byte not zero");
  chk_timer_pin: assert property (ctrl1_ff[7:6] == MODE_TMR [*2]
    |-> !timer_output_pin) else $error("pin driven in timer mode");
  chk_pwm_forced: assert property ((ctrl1_ff[7:6] == MODE_PWM && !ctrl1_ff[5]
    && ctrl0_ff[C0_ON_BIT] && $stable(ctrl1_ff) && $stable(ctrl0_ff)) [*2]
    |-> timer_output_pin == (ctrl1_ff[C1_OC_BIT] ^ ctrl1_ff[C1_POL_BIT] ^ !ctrl1_ff[4]))
    else $error("forced pwm level wrong");
  chk_init_level: assert property (on_rise_s and ctrl1_ff[7:6] == MODE_CMP
    |-> ##[1:2] timer_output_pin == (ctrl1_ff[C1_OC_BIT] ^ ctrl1_ff[C1_POL_BIT]))
    else $error("initial level not loaded");
endmodule : compact_timer_asserts
bind compact_timer compact_timer_asserts i_compact_timer_asserts (.clk(clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_output_pin(timer_output_pin));
`default_nettype wire

/* compact_timer_bench.sv */
// Self-checking bench for the compact timer
`timescale 1ns/1ns
`default_nettype none
module compact_timer_bench
  import compact_timer_pkg::*;
;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr;
  logic        high_clk_tick, tbc_clk_tick, external_count_input;
  logic        timer_output_pin, irq_pulse;
  logic [4:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [31:0] exp_q[$];
  logic [31:0] seed = 32'h6;
  int          n_mismatch = 0, num_checks = 0, cyc = 0, t0, t1;
  int          n_irq = 0, irq0;
  logic [15:0] cnt;
  logic [7:0]  r, s;
  compact_timer i_compact_timer (.clk(clk), .rst(rst), .high_clk_tick(high_clk_tick),
    .tbc_clk_tick(tbc_clk_tick), .external_count_input(external_count_input),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_output_pin(timer_output_pin), .irq_pulse(irq_pulse));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(logic wr, logic [4:0] a, logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    t1 = cyc;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(logic [4:0] a, logic [7:0] e);
    exp_q.push_back({24'h0, e});
    apb(1'b0, a, 8'h00);
  endtask : rd
  task automatic summarize();
    if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Slow tick and pin stimulus
  always @(posedge clk) begin
    cyc <= cyc + 1;
    high_clk_tick <= cyc[2:0] == 3'h0;
    tbc_clk_tick <= cyc[4:0] == 5'h0;
    external_count_input <= cyc[3];
    if (irq_pulse === 1'b1) n_irq <= n_irq + 1;
  end
  always @(posedge clk)
    if (psel && penable && !pwrite && pready === 1'b1) check(prdata, exp_q.pop_front());
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 5'h00;
    pwdata = 32'h0;
    high_clk_tick = 1'b0;
    tbc_clk_tick = 1'b0;
    external_count_input = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) rd(5'(4 * i), 8'h00);
    rd(5'h03, 8'h00);
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      apb(1'b1, OFF_CTRL1, r);
      rd(OFF_CTRL1, r);
      apb(1'b1, OFF_CTRL0, {r[7], 3'(i), 4'hF});
      rd(OFF_CTRL0, {r[7], 3'(i), 4'h8});
      apb(1'b1, OFF_CNT_HI, r);
      rd(OFF_CNT_HI, 8'h00);
      apb(1'b1, OFF_PERIOD, r);
      rd(OFF_PERIOD, r);
    end
    r = rnd();
    s = rnd();
    apb(1'b1, OFF_CMPA_LO, r);
    rd(OFF_CMPA_LO, r);
    rd(OFF_CMPA_HI, 8'h00);
    apb(1'b1, OFF_CMPA_HI, s);
    rd(OFF_CMPA_LO, 8'h00);
    apb(1'b1, OFF_CMPA_LO, r);
    apb(1'b1, OFF_CMPA_HI, s);
    rd(OFF_CMPA_HI, s);
    rd(OFF_CMPA_LO, r);
    apb(1'b1, OFF_CMPA_LO, 8'h10);
    apb(1'b1, OFF_CMPA_HI, 8'h00);
    apb(1'b1, OFF_PERIOD, 8'h00);
    apb(1'b1, OFF_CTRL0, 8'h10);
    apb(1'b1, OFF_CTRL1, 8'hC0);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, OFF_CTRL0, 8'h18);
      t0 = t1;
      repeat (k * (300 + rnd())) @(posedge clk);
      apb(1'b1, OFF_CTRL0, 8'h98);
      cnt = 16'(t1 - t0 - 1);
      repeat (20) @(posedge clk);
      check({31'h0, timer_output_pin}, 32'h0);
      rd(OFF_CNT_HI, cnt[15:8]);
      rd(OFF_CNT_LO, cnt[7:0]);
      apb(1'b1, OFF_CTRL0, 8'h10);
      rd(OFF_CNT_HI, cnt[15:8]);
    end
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      apb(1'b1, OFF_CTRL0, 8'h10);
      apb(1'b1, OFF_CTRL1, {2'b00, 2'(i), r[3:2], 2'b00});
      apb(1'b1, OFF_CTRL0, 8'h18);
      irq0 = n_irq;
      repeat (2) @(posedge clk);
      check({31'h0, timer_output_pin}, {31'h0, r[3] ^ r[2]});
      repeat (40) @(posedge clk);
      s[0] = (i == 0) ? r[3] : (i == 3) ? ~r[3] : i[1];
      check({31'h0, timer_output_pin}, {31'h0, s[0] ^ r[2]});
      check(32'(n_irq - irq0), 32'h1);
      rd(OFF_STATUS, 8'h01);
      apb(1'b1, OFF_STATUS, 8'h03);
      rd(OFF_STATUS, 8'h00);
    end
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      apb(1'b1, OFF_CTRL0, 8'h10);
      apb(1'b1, OFF_CTRL1, {2'b10, 1'b0, i[0], r[3:2], 2'b00});
      apb(1'b1, OFF_CTRL0, 8'h18);
      repeat (3) @(posedge clk);
      check({31'h0, timer_output_pin}, {31'h0, ~(i[0] ^ r[3]) ^ r[2]});
    end
    apb(1'b1, OFF_PERIOD, 8'h01);
    for (int j = 0; j < 2; j++) begin
      apb(1'b1, OFF_CTRL0, 8'h10);
      apb(1'b1, OFF_CTRL1, 8'hA8 | 8'(2 * j));
      apb(1'b1, OFF_CTRL0, 8'h18);
      repeat (300) @(posedge clk);
      cnt = 16'h0;
      repeat (256) begin
        @(posedge clk);
        cnt += 16'(timer_output_pin);
      end
      check({16'h0, cnt}, j ? 32'd256 : 32'd16);
    end
    summarize();
  end
endmodule : compact_timer_bench
`default_nettype wire
